// *** pkg/spfm_pkg.sv ***
// Constants, types and bus carriers for the four-mode serial port
// Behaviour
// - A write to the buffer while the engine is idle loads the transmit shifter and starts sending.
// - A read of the buffer returns the separate receive register.
// - Two control mode bits pick shift, 8-bit variable, 9-bit fixed, 9-bit variable.
// - Mode 0 moves data on the rx pin, clocks on tx pin at clock/12, LSB first.
// - Mode 0 reception starts once receive-done is clear and receive-enable set.
// - Mode 1 frame is start 0, eight data bits LSB first, stop 1.
// - Mode 1 with filter clear puts stop bit in rx ninth bit; mode 0 leaves it.
// - Modes 2 and 3 send tx ninth bit and store received ninth bit.
// - Mode 2 bit rate is clock/64, or clock/32 with baud doubler set.
// - Timer 1 source gives overflow/32, or overflow/16 with baud doubler set.
// - Timer 2 selected direction runs at overflow/16, ignoring the baud doubler.
// - Mode 3 equals mode 2 but takes its rate from the timer source.
// - Frames in modes 1 to 3 are accepted only while receive-enable is set.
// - Transmit-done is set by hardware at transfer end, cleared only by software.
// - Receive-done is set by hardware at reception end, cleared by software.
// - Software writes to done flags act as hardware updates on the interrupt.
// - One interrupt raised when a done flag is set and the enable is set.
// - Priority bit puts the serial interrupt in the high or low group.
// - Timer 2 is never a rate source when a capture unit is built in.
// - With filter set in modes 2/3, only ninth bit one raises receive-done.
// - Receive is double buffered; a new frame may arrive before a read.
package spfm_pkg;

  // Register indices and byte addresses (index times four)
  localparam logic [7:0]  IDX_POWER   = 8'h87;
  localparam logic [7:0]  IDX_CTRL    = 8'h98;
  localparam logic [7:0]  IDX_BUF     = 8'h99;
  localparam logic [7:0]  IDX_IE      = 8'hA8;
  localparam logic [7:0]  IDX_IP      = 8'hB8;
  localparam logic [7:0]  IDX_T2CTRL  = 8'hC8;
  localparam logic [11:0] ADDR_POWER  = {2'h0, IDX_POWER, 2'h0};
  localparam logic [11:0] ADDR_CTRL   = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_BUF    = {2'h0, IDX_BUF, 2'h0};
  localparam logic [11:0] ADDR_IE     = {2'h0, IDX_IE, 2'h0};
  localparam logic [11:0] ADDR_IP     = {2'h0, IDX_IP, 2'h0};
  localparam logic [11:0] ADDR_T2CTRL = {2'h0, IDX_T2CTRL, 2'h0};
  localparam logic [7:0]  REG_RESET   = 8'h00;

  // Field positions
  localparam int CTRL_MODE_HI = 7;
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_MPF     = 5;
  localparam int CTRL_REN     = 4;
  localparam int CTRL_TB8     = 3;
  localparam int CTRL_RB8     = 2;
  localparam int CTRL_TI      = 1;
  localparam int CTRL_RI      = 0;
  localparam int PWR_DOUBLER  = 7;
  localparam int IE_UART      = 4;
  localparam int IP_UART      = 4;
  localparam int T2_RXSEL     = 5;
  localparam int T2_TXSEL     = 4;

  // Interrupt identity and rate constants
  localparam logic [7:0] IRQ_VECTOR    = 8'h23;
  localparam logic [2:0] IRQ_NAT_PRIO  = 3'h5;
  localparam int         MODE0_DIV     = 12;
  localparam logic [3:0] OVS_LAST      = 4'hF;
  localparam logic [3:0] OVS_MID       = 4'h7;
  localparam logic [1:0] FIX_SLOW_LAST = 2'h3;
  localparam logic [3:0] TX_LAST_8BIT  = 4'h9;
  localparam logic [3:0] TX_LAST_9BIT  = 4'hA;
  localparam logic [3:0] RX_LAST_8BIT  = 4'h8;
  localparam logic [3:0] RX_LAST_9BIT  = 4'h9;
  localparam logic [3:0] SYNC_LAST_BIT = 4'h7;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_DECERR   = 2'h3;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0, MODE_8VAR = 2'h1, MODE_9FIX = 2'h2, MODE_9VAR = 2'h3
  } spfm_mode_t;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'h0, ENG_ASYNC = 2'h1, ENG_SYNC_TX = 2'h2, ENG_SYNC_RX = 2'h3
  } spfm_eng_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h2
  } spfm_rx_t;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } spfm_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } spfm_axi_rsp_t;

endpackage

// *** rtl/spfm_uart.sv ***
// Four-mode serial port with AXI4-Lite register slave
`timescale 1ns/1ps
module spfm_uart #(
  parameter bit          HAS_CAPTURE_UNIT = 1'b0,
  parameter int unsigned MODE0_DIV        = spfm_pkg::MODE0_DIV
) (
  // Clock, reset, enable
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire logic                  clockEn,
  // Register bus
  input  wire spfm_pkg::spfm_axi_req_t axiReq,
  output spfm_pkg::spfm_axi_rsp_t    axiRsp,
  // Baud sources, same clock domain
  input  wire logic                  timer1Ovf,
  input  wire logic                  timer2Ovf,
  // Serial pins
  input  wire logic                  rxLineIn,
  output logic                       rxLineOut,
  output logic                       rxLineOe,
  output logic                       txLine,
  // Interrupt request
  output logic                       uartIrq,
  output logic                       uartIrqHigh,
  output logic [7:0]                 uartIrqVector
);

  localparam logic [3:0] PH_LAST = 4'(MODE0_DIV - 1);
  localparam logic [3:0] PH_HALF = 4'(MODE0_DIV / 2);

  // Refuse dividers the phase counter cannot serve
  if (MODE0_DIV < 2 || MODE0_DIV > 16 || (MODE0_DIV % 2) != 0) begin : g_bad_div
    $error("MODE0_DIV must be even and within 2 to 16");
  end

  // Bus state
  logic        awHeld_q, wHeld_q, bvalid_q, rvalid_q, wStrb0_q;
  logic [11:0] awAddr_q;
  logic [7:0]  wData_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // Register state
  logic [7:0]  ctrl_q, ctrl_d, power_q, ie_q, ip_q, rxBuf_q;
  logic [1:0]  t2Sel_q;
  // Engine state
  spfm_pkg::spfm_eng_t eng_q;
  logic [10:0] sh_q;
  logic [3:0]  bit_q, tick_q, ph_q;
  logic [1:0]  fixDiv_q;
  logic        t1Half_q;
  // Receive state
  spfm_pkg::spfm_rx_t rxSt_q;
  logic [9:0]  rxSh_q;
  logic [3:0]  rxTk_q, rxBit_q;
  logic        rxMeta_q, rxS_q, rxPrev_q;
  // Registered pin drive
  logic        txLine_q, rxOut_q, rxOe_q;

  // Bus handshake decode
  wire awReady  = !awHeld_q && !bvalid_q;
  wire wReady   = !wHeld_q && !bvalid_q;
  wire awTake   = axiReq.awvalid && awReady;
  wire wTake    = axiReq.wvalid && wReady;
  wire doWrite  = awHeld_q && wHeld_q && !bvalid_q;
  wire arTake   = axiReq.arvalid && !rvalid_q;
  wire wrEn     = doWrite && wStrb0_q;
  wire wrCtrl   = wrEn && awAddr_q == spfm_pkg::ADDR_CTRL;
  wire wrBuf    = wrEn && awAddr_q == spfm_pkg::ADDR_BUF;
  wire wrPower  = wrEn && awAddr_q == spfm_pkg::ADDR_POWER;
  wire wrIe     = wrEn && awAddr_q == spfm_pkg::ADDR_IE;
  wire wrIp     = wrEn && awAddr_q == spfm_pkg::ADDR_IP;
  wire wrT2     = wrEn && awAddr_q == spfm_pkg::ADDR_T2CTRL;
  wire wrMapped = awAddr_q inside {spfm_pkg::ADDR_CTRL, spfm_pkg::ADDR_BUF,
                  spfm_pkg::ADDR_POWER, spfm_pkg::ADDR_IE, spfm_pkg::ADDR_IP,
                  spfm_pkg::ADDR_T2CTRL};
  wire rdMapped = axiReq.araddr inside {spfm_pkg::ADDR_CTRL, spfm_pkg::ADDR_BUF,
                  spfm_pkg::ADDR_POWER, spfm_pkg::ADDR_IE, spfm_pkg::ADDR_IP,
                  spfm_pkg::ADDR_T2CTRL};
  wire [7:0] t2Read = {2'h0, t2Sel_q, 4'h0};

  // Read selection; the buffer address returns the receive side
  wire [7:0] rdMux =
    (axiReq.araddr == spfm_pkg::ADDR_CTRL)    ? ctrl_q  :
    (axiReq.araddr == spfm_pkg::ADDR_BUF)     ? rxBuf_q :
    (axiReq.araddr == spfm_pkg::ADDR_POWER)   ? power_q :
    (axiReq.araddr == spfm_pkg::ADDR_IE)      ? ie_q    :
    (axiReq.araddr == spfm_pkg::ADDR_IP)      ? ip_q    :
    (axiReq.araddr == spfm_pkg::ADDR_T2CTRL)  ? t2Read  : 8'h00;

  assign axiRsp = '{awready: awReady, wready: wReady, bvalid: bvalid_q, bresp: bresp_q,
                    arready: !rvalid_q, rvalid: rvalid_q, rdata: rdata_q,
                    rresp: rresp_q};

  // Control field decode
  wire  spfm_pkg::spfm_mode_t mode = spfm_pkg::spfm_mode_t'(ctrl_q[7:6]);
  wire  ren     = ctrl_q[spfm_pkg::CTRL_REN];
  wire  mpf     = ctrl_q[spfm_pkg::CTRL_MPF];
  wire  riFlag  = ctrl_q[spfm_pkg::CTRL_RI];
  wire  tiFlag  = ctrl_q[spfm_pkg::CTRL_TI];
  wire  doubler = power_q[spfm_pkg::PWR_DOUBLER];
  wire  isMode1 = mode == spfm_pkg::MODE_8VAR;

  // Rate ticks at sixteen times the bit rate
  wire fixTick = doubler ? fixDiv_q[0] : fixDiv_q == spfm_pkg::FIX_SLOW_LAST;
  wire t1Tick  = timer1Ovf && (doubler || t1Half_q);
  wire t2Ok    = !HAS_CAPTURE_UNIT;
  wire txT2    = t2Ok && t2Sel_q[0];
  wire rxT2    = t2Ok && t2Sel_q[1];
  // Mode 3 differs from mode 2 only here
  wire txTick  = (mode == spfm_pkg::MODE_9FIX) ? fixTick :
                 (txT2 ? timer2Ovf : t1Tick);
  wire rxTick  = (mode == spfm_pkg::MODE_9FIX) ? fixTick :
                 (rxT2 ? timer2Ovf : t1Tick);

  // Transmit and shift engine decode
  wire [3:0] txLast  = isMode1 ? spfm_pkg::TX_LAST_8BIT : spfm_pkg::TX_LAST_9BIT;
  wire [10:0] frame  = isMode1 ? {2'b11, wData_q, 1'b0} :
                       {1'b1, ctrl_q[spfm_pkg::CTRL_TB8], wData_q, 1'b0};
  wire engIdle   = eng_q == spfm_pkg::ENG_IDLE;
  wire syncStart = engIdle && !wrBuf && mode == spfm_pkg::MODE_SHIFT && ren && !riFlag;
  wire phEnd     = ph_q == PH_LAST;
  wire syncEnd   = phEnd && bit_q == spfm_pkg::SYNC_LAST_BIT;
  wire asyncEnd  = eng_q == spfm_pkg::ENG_ASYNC && txTick &&
                   tick_q == spfm_pkg::OVS_LAST && bit_q == txLast;
  wire txDoneSet = asyncEnd || (eng_q == spfm_pkg::ENG_SYNC_TX && syncEnd);
  wire syncRxEnd = eng_q == spfm_pkg::ENG_SYNC_RX && syncEnd;
  wire [7:0] syncRxByte = {rxS_q, sh_q[7:1]};

  // Asynchronous receive decode
  wire [3:0] rxLast  = isMode1 ? spfm_pkg::RX_LAST_8BIT : spfm_pkg::RX_LAST_9BIT;
  wire [9:0] rxNext  = {rxS_q, rxSh_q[9:1]};
  wire rxSample      = rxSt_q == spfm_pkg::RX_DATA && rxTick && rxTk_q == spfm_pkg::OVS_LAST;
  wire rxFrameEnd    = rxSample && rxBit_q == rxLast;
  wire [7:0] rxByte  = isMode1 ? rxNext[8:1] : rxNext[7:0];
  wire rxNinth       = isMode1 ? rxNext[9] : rxNext[8];
  // Filter drops frames whose ninth bit is zero
  wire rxAccept      = rxFrameEnd && !riFlag && (!mpf || rxNinth);
  wire rxFall        = rxPrev_q && !rxS_q;

  // Control next value; hardware sets win over a software clear
  always_comb begin
    ctrl_d = wrCtrl ? wData_q : ctrl_q;
    if (rxAccept) begin
      ctrl_d[spfm_pkg::CTRL_RB8] = rxNinth;
      ctrl_d[spfm_pkg::CTRL_RI]  = 1'b1;
    end
    if (syncRxEnd) begin
      ctrl_d[spfm_pkg::CTRL_RI] = 1'b1;
    end
    if (txDoneSet) begin
      ctrl_d[spfm_pkg::CTRL_TI] = 1'b1;
    end
  end

  // Bus channel holding and answers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q  <= spfm_pkg::RESP_OKAY;
      rresp_q  <= spfm_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      awAddr_q <= 12'h000;
      wData_q  <= 8'h00;
      wStrb0_q <= 1'b0;
    end else if (clockEn) begin
      if (awTake) begin
        awHeld_q <= 1'b1;
        awAddr_q <= axiReq.awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (wTake) begin
        wHeld_q  <= 1'b1;
        wData_q  <= axiReq.wdata[7:0];
        wStrb0_q <= axiReq.wstrb[0];
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
      if (doWrite) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wrMapped ? spfm_pkg::RESP_OKAY : spfm_pkg::RESP_DECERR;
      end else if (axiReq.bready) begin
        bvalid_q <= 1'b0;
      end
      if (arTake) begin
        rvalid_q <= 1'b1;
        rdata_q  <= {24'h00_0000, rdMux};
        rresp_q  <= rdMapped ? spfm_pkg::RESP_OKAY : spfm_pkg::RESP_DECERR;
      end else if (axiReq.rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Software registers and receive buffer
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_q  <= spfm_pkg::REG_RESET;
      power_q <= spfm_pkg::REG_RESET;
      ie_q    <= spfm_pkg::REG_RESET;
      ip_q    <= spfm_pkg::REG_RESET;
      t2Sel_q <= 2'h0;
      rxBuf_q <= spfm_pkg::REG_RESET;
    end else if (clockEn) begin
      ctrl_q <= ctrl_d;
      if (wrPower) power_q <= wData_q;
      if (wrIe) ie_q <= wData_q;
      if (wrIp) ip_q <= wData_q;
      if (wrT2) t2Sel_q <= {wData_q[spfm_pkg::T2_RXSEL], wData_q[spfm_pkg::T2_TXSEL]};
      // Shifters stay apart from the buffer, so a new frame may start
      if (rxAccept) begin
        rxBuf_q <= rxByte;
      end else if (syncRxEnd) begin
        rxBuf_q <= syncRxByte;
      end
    end
  end

  // Rate prescalers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      fixDiv_q <= 2'h0;
      t1Half_q <= 1'b0;
    end else if (clockEn) begin
      fixDiv_q <= fixDiv_q + 2'h1;
      if (timer1Ovf) t1Half_q <= !t1Half_q;
    end
  end

  // Transmit engine, also running both mode 0 directions
  always_ff @(posedge clock) begin
    if (!rstn) begin
      eng_q  <= spfm_pkg::ENG_IDLE;
      sh_q   <= 11'h7FF;
      bit_q  <= 4'h0;
      tick_q <= 4'h0;
      ph_q   <= 4'h0;
    end else if (clockEn) begin
      case (eng_q)
        spfm_pkg::ENG_IDLE: begin
          bit_q  <= 4'h0;
          tick_q <= 4'h0;
          ph_q   <= 4'h0;
          if (wrBuf && mode == spfm_pkg::MODE_SHIFT) begin
            eng_q <= spfm_pkg::ENG_SYNC_TX;
            sh_q  <= {3'b111, wData_q};
          end else if (wrBuf) begin
            eng_q <= spfm_pkg::ENG_ASYNC;
            sh_q  <= frame;
          end else if (syncStart) begin
            eng_q <= spfm_pkg::ENG_SYNC_RX;
          end
        end
        spfm_pkg::ENG_ASYNC: begin
          if (txTick) begin
            tick_q <= tick_q + 4'h1;
            if (tick_q == spfm_pkg::OVS_LAST) begin
              sh_q  <= {1'b1, sh_q[10:1]};
              bit_q <= bit_q + 4'h1;
              if (bit_q == txLast) eng_q <= spfm_pkg::ENG_IDLE;
            end
          end
        end
        spfm_pkg::ENG_SYNC_TX, spfm_pkg::ENG_SYNC_RX: begin
          ph_q <= phEnd ? 4'h0 : ph_q + 4'h1;
          if (phEnd) begin
            bit_q <= bit_q + 4'h1;
            sh_q  <= (eng_q == spfm_pkg::ENG_SYNC_TX) ? {1'b1, sh_q[10:1]} :
                     {3'b111, syncRxByte};
            if (syncEnd) eng_q <= spfm_pkg::ENG_IDLE;
          end
        end
        default: eng_q <= spfm_pkg::ENG_IDLE;
      endcase
    end
  end

  // Pin synchroniser and asynchronous receiver
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rxMeta_q <= 1'b1;
      rxS_q    <= 1'b1;
      rxPrev_q <= 1'b1;
      rxSt_q   <= spfm_pkg::RX_IDLE;
      rxSh_q   <= 10'h000;
      rxTk_q   <= 4'h0;
      rxBit_q  <= 4'h0;
    end else if (clockEn) begin
      rxMeta_q <= rxLineIn;
      rxS_q    <= rxMeta_q;
      rxPrev_q <= rxS_q;
      if (!ren || mode == spfm_pkg::MODE_SHIFT) begin
        rxSt_q <= spfm_pkg::RX_IDLE;
      end else begin
        case (rxSt_q)
          spfm_pkg::RX_IDLE: begin
            rxTk_q  <= 4'h0;
            rxBit_q <= 4'h0;
            if (rxFall) rxSt_q <= spfm_pkg::RX_START;
          end
          spfm_pkg::RX_START: begin
            if (rxTick) begin
              rxTk_q <= rxTk_q + 4'h1;
              if (rxTk_q == spfm_pkg::OVS_MID) begin
                rxTk_q <= 4'h0;
                rxSt_q <= rxS_q ? spfm_pkg::RX_IDLE : spfm_pkg::RX_DATA;
              end
            end
          end
          spfm_pkg::RX_DATA: begin
            if (rxTick) rxTk_q <= rxTk_q + 4'h1;
            if (rxSample) begin
              rxSh_q  <= rxNext;
              rxBit_q <= rxBit_q + 4'h1;
              if (rxFrameEnd) rxSt_q <= spfm_pkg::RX_IDLE;
            end
          end
          default: rxSt_q <= spfm_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // Pin drive values; mode 0 clock is low for the first half of each bit
  wire syncBusy = eng_q == spfm_pkg::ENG_SYNC_TX || eng_q == spfm_pkg::ENG_SYNC_RX;
  wire txLineD  = syncBusy ? (ph_q >= PH_HALF) :
                  (eng_q == spfm_pkg::ENG_ASYNC) ? sh_q[0] : 1'b1;
  wire rxOeD    = eng_q == spfm_pkg::ENG_SYNC_TX;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      txLine_q <= 1'b1;
      rxOut_q  <= 1'b1;
      rxOe_q   <= 1'b0;
    end else if (clockEn) begin
      txLine_q <= txLineD;
      rxOut_q  <= rxOeD ? sh_q[0] : 1'b1;
      rxOe_q   <= rxOeD;
    end
  end

  // Pins and interrupt request
  assign txLine        = txLine_q;
  assign rxLineOut     = rxOut_q;
  assign rxLineOe      = rxOe_q;
  assign uartIrq       = ie_q[spfm_pkg::IE_UART] && (tiFlag || riFlag);
  assign uartIrqHigh   = uartIrq && ip_q[spfm_pkg::IP_UART];
  assign uartIrqVector = spfm_pkg::IRQ_VECTOR;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_tx_done_sticky: assert property (clockEn && tiFlag && !wrCtrl |=> tiFlag)
    else $error("transmit done flag dropped without a software write");
  a_rx_buf_read: assert property (clockEn && arTake && axiReq.araddr == spfm_pkg::ADDR_BUF
    |=> rdata_q[7:0] == $past(rxBuf_q) && rvalid_q)
    else $error("buffer read did not return the receive register");
  a_write_starts: assert property (clockEn && wrBuf && engIdle && mode != spfm_pkg::MODE_SHIFT
    |=> eng_q == spfm_pkg::ENG_ASYNC ##0 sh_q[0] == 1'b0)
    else $error("buffer write did not start an asynchronous frame");
  a_mode0_clock: assert property (syncBusy && ph_q != 4'h0 && ph_q <= PH_HALF
    |-> !txLine_q)
    else $error("mode 0 shift clock high in first half of bit");
  a_irq_combine: assert property (clockEn && ie_q[spfm_pkg::IE_UART] && !wrIe &&
    (txDoneSet || rxAccept || syncRxEnd) |=> uartIrq)
    else $error("done event with enable set raised no serial interrupt");
  a_irq_group: assert property (uartIrqHigh |-> ip_q[spfm_pkg::IP_UART] && uartIrq)
    else $error("high group interrupt without priority bit");
  a_rx_disabled: assert property (clockEn && !ren |=> rxSt_q == spfm_pkg::RX_IDLE)
    else $error("receiver active while disabled");
  a_mp_filter: assert property (clockEn && rxFrameEnd && mpf && !rxNinth && !wrCtrl
    |=> $stable(riFlag) && $stable(rxBuf_q))
    else $error("filtered frame raised receive done");
  a_false_start: assert property (clockEn && rxSt_q == spfm_pkg::RX_START && ren &&
    rxTick && rxTk_q == spfm_pkg::OVS_MID && rxS_q |=> rxSt_q == spfm_pkg::RX_IDLE)
    else $error("short start pulse accepted");

  c_async_tx: cover property (clockEn && asyncEnd);
  c_async_rx: cover property (clockEn && rxAccept && !isMode1);
  c_sync_rx: cover property (clockEn && syncRxEnd);
  c_filtered: cover property (clockEn && rxFrameEnd && mpf && !rxNinth);

endmodule

// *** tb/spfm_far_end.sv ***
// Far-end serial device: line sampler and frame sender
`timescale 1ns/1ps
module spfm_far_end (
  // Clock and bit pacing
  input  wire logic clock,
  input  var  int   bitClocks,
  // Serial lines
  input  wire logic txLine,
  input  wire logic rxData,
  output logic      rxLine,
  // Last captured bits after a start edge
  output logic [9:0] gotFrame
);
  int i;
  // Idle line stays high
  initial rxLine = 1'b1;
  // Sample ten bits at bit centres after each start edge
  initial forever begin
    @(negedge txLine);
    repeat (bitClocks / 2) @(posedge clock);
    for (i = 0; i < 10; i++) begin
      repeat (bitClocks) @(posedge clock);
      gotFrame[i] = txLine;
    end
  end
  // Start 0, nine bits LSB first, stop 1, then idle high
  task automatic send(input logic [8:0] bits);
    logic [10:0] f;
    f = {1'b1, bits, 1'b0};
    for (int j = 0; j < 11; j++) begin
      rxLine <= f[j];
      repeat (bitClocks) @(posedge clock);
    end
  endtask
  // Mode 0 partner: take a bit after each rising shift clock, LSB first
  task automatic shift_in(output logic [7:0] b, output int n);
    logic p;
    int   j;
    p = txLine;
    j = 0;
    n = 0;
    while (j < 8 && n < 3000) begin
      @(posedge clock);
      n++;
      if (txLine && !p) begin
        b[j] = rxData;
        j++;
      end
      p = txLine;
    end
  endtask
  // Mode 0 partner: present a bit after each falling shift clock, LSB first
  task automatic shift_out(input logic [7:0] b, output int n);
    logic p;
    int   j;
    p = txLine;
    j = 0;
    n = 0;
    while (j < 8 && n < 3000) begin
      @(posedge clock);
      n++;
      if (!txLine && p) begin
        rxLine <= b[j];
        j++;
      end
      p = txLine;
    end
  endtask
endmodule

// *** tb/serial_port_four_mode_tb_top.sv ***
// Self-checking bench for the four-mode serial port
`timescale 1ns/1ps
module serial_port_four_mode_tb_top;
  logic                    clock = 1'b0;
  logic                    rstn = 1'b0;
  logic                    ovf = 1'b0;
  int                      bitClocks = 64;
  int                      miscompares = 0;
  int                      checks = 0;
  spfm_pkg::spfm_axi_req_t req = '0;
  spfm_pkg::spfm_axi_rsp_t rsp;
  logic [31:0]             rd;
  logic [1:0]              resp;
  logic                    rxLine, rxOut, rxOe, rxPin, txLine, irq, irqHigh;
  logic [7:0]              irqVec;
  logic [9:0]              gotFrame;

  // Clock and shared overflow pulses every second cycle
  always #5 clock = ~clock;
  always @(posedge clock) ovf <= ~ovf;
  // Receive pin level from both drivers
  assign rxPin = rxOe ? rxOut : rxLine;

  spfm_uart dut (.clock(clock), .rstn(rstn), .clockEn(1'b1), .axiReq(req), .axiRsp(rsp),
    .timer1Ovf(ovf), .timer2Ovf(ovf), .rxLineIn(rxPin), .rxLineOut(rxOut), .rxLineOe(rxOe),
    .txLine(txLine), .uartIrq(irq), .uartIrqHigh(irqHigh), .uartIrqVector(irqVec));
  spfm_far_end far (.clock(clock), .bitClocks(bitClocks), .txLine(txLine), .rxData(rxPin),
    .rxLine(rxLine), .gotFrame(gotFrame));

  task give_verdict;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task limit(input int n);
    if (n >= 3000) begin
      miscompares++;
      give_verdict;
    end
  endtask
  // Bus write, each channel released once taken
  task axw(input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(posedge clock);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      n++;
    end while (rsp.bvalid !== 1'b1 && n < 3000);
    req.bready <= 1'b0;
    resp = rsp.bresp;
    limit(n);
    @(posedge clock);
  endtask
  // Bus read
  task axr(input logic [11:0] a);
    int n;
    n = 0;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clock);
      if (rsp.arready) req.arvalid <= 1'b0;
      n++;
    end while (rsp.rvalid !== 1'b1 && n < 3000);
    req.rready <= 1'b0;
    rd = rsp.rdata;
    resp = rsp.rresp;
    limit(n);
    @(posedge clock);
  endtask
  task wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 3000) begin
      @(posedge clock);
      n++;
    end
    limit(n);
  endtask

  // Reset values, unmapped place, enable and priority
  task t_regs;
    axr(spfm_pkg::ADDR_CTRL);
    chk(rd, 32'h0);
    axr(spfm_pkg::ADDR_BUF);
    chk(rd, 32'h0);
    axr(12'h004);
    chk(32'(resp), 32'(spfm_pkg::RESP_DECERR));
    axw(spfm_pkg::ADDR_IE, 8'h10);
    axw(spfm_pkg::ADDR_IP, 8'h10);
    axr(spfm_pkg::ADDR_IE);
    chk(rd, 32'h10);
    $display("test regs done");
  endtask
  // Mode 1, timer 1, no doubler: 64 clocks a bit
  task t_tx1;
    bitClocks = 64;
    axw(spfm_pkg::ADDR_CTRL, 8'h40);
    axw(spfm_pkg::ADDR_BUF, 8'h3C);
    wait_irq(1'b1);
    repeat (bitClocks) @(posedge clock);
    chk(32'(gotFrame), 32'h33C);
    chk(32'(irqHigh), 32'h1);
    chk(32'(irqVec), 32'h23);
    axr(spfm_pkg::ADDR_CTRL);
    chk(rd, 32'h42);
    axw(spfm_pkg::ADDR_CTRL, 8'h40);
    chk(32'(irq), 32'h0);
    axw(spfm_pkg::ADDR_CTRL, 8'h42);
    chk(32'(irq), 32'h1);
    axw(spfm_pkg::ADDR_CTRL, 8'h40);
    $display("test tx mode 1 done");
  endtask
  // Mode 1 receive; buffer holds while the next frame arrives
  task t_rx1;
    axw(spfm_pkg::ADDR_CTRL, 8'h50);
    far.send(9'h1C3);
    wait_irq(1'b1);
    axr(spfm_pkg::ADDR_CTRL);
    chk(rd, 32'h55);
    axw(spfm_pkg::ADDR_CTRL, 8'h50);
    fork
      far.send(9'h15A);
      begin
        repeat (5 * bitClocks) @(posedge clock);
        axr(spfm_pkg::ADDR_BUF);
        chk(rd, 32'hC3);
      end
    join
    wait_irq(1'b1);
    axr(spfm_pkg::ADDR_BUF);
    chk(rd, 32'h5A);
    $display("test rx mode 1 done");
  endtask
  // Mode 0 transmit then receive through the shift partner
  task t_m0;
    logic [7:0] v;
    int         n;
    axw(spfm_pkg::ADDR_CTRL, 8'h00);
    axw(spfm_pkg::ADDR_BUF, 8'h5A);
    far.shift_in(v, n);
    limit(n);
    chk(32'(v), 32'h5A);
    wait_irq(1'b1);
    repeat (2) @(posedge clock);
    chk(32'(rxOe), 32'h0);
    chk(32'(txLine), 32'h1);
    axw(spfm_pkg::ADDR_CTRL, 8'h00);
    fork
      far.shift_out(8'hC5, n);
      axw(spfm_pkg::ADDR_CTRL, 8'h10);
    join
    limit(n);
    wait_irq(1'b1);
    axr(spfm_pkg::ADDR_BUF);
    chk(rd, 32'hC5);
    axr(spfm_pkg::ADDR_CTRL);
    chk(rd, 32'h11);
    $display("test mode 0 done");
  endtask
  // Mode 3, timer 2 transmit clock, ninth bit set: 32 clocks a bit
  task t_tx3;
    bitClocks = 32;
    axw(spfm_pkg::ADDR_T2CTRL, 8'h10);
    axw(spfm_pkg::ADDR_CTRL, 8'hC8);
    axw(spfm_pkg::ADDR_BUF, 8'h81);
    wait_irq(1'b1);
    repeat (bitClocks) @(posedge clock);
    chk(32'(gotFrame), 32'h381);
    axw(spfm_pkg::ADDR_CTRL, 8'h80);
    axw(spfm_pkg::ADDR_T2CTRL, 8'h00);
    $display("test tx mode 3 done");
  endtask
  // Mode 2 doubled, filter on, then reception disabled
  task t_rx2;
    axw(spfm_pkg::ADDR_POWER, 8'h80);
    axw(spfm_pkg::ADDR_CTRL, 8'hB0);
    far.send(9'h05A);
    repeat (bitClocks) @(posedge clock);
    chk(32'(irq), 32'h0);
    far.send(9'h1A5);
    wait_irq(1'b1);
    axr(spfm_pkg::ADDR_BUF);
    chk(rd, 32'hA5);
    axr(spfm_pkg::ADDR_CTRL);
    chk(rd, 32'hB5);
    axw(spfm_pkg::ADDR_CTRL, 8'h80);
    far.send(9'h1C3);
    repeat (bitClocks) @(posedge clock);
    chk(32'(irq), 32'h0);
    $display("test rx mode 2 done");
  endtask

  // Reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_regs;
    t_tx1;
    t_rx1;
    t_tx3;
    t_rx2;
    t_m0;
    give_verdict;
  end
endmodule
